// *** src/pmp_pkg.sv ***
package pmp_pkg;
    // Register map (byte addresses on APB).
    localparam logic [11:0] ADDR_CTRL = 12'h000;
    localparam logic [11:0] ADDR_CMD = 12'h004;
    localparam logic [11:0] ADDR_SRC_LO = 12'h008;
    localparam logic [11:0] ADDR_SRC_HI = 12'h00c;
    localparam logic [11:0] ADDR_RES_LO = 12'h010;
    localparam logic [11:0] ADDR_RES_HI = 12'h014;
    localparam logic [11:0] ADDR_TAG = 12'h018;
    localparam logic [11:0] ADDR_STATUS = 12'h01c;
    localparam logic [11:0] ADDR_PREG = 12'h020;
    localparam logic [11:0] ADDR_PREG_LAST = 12'h05c;
    // Control register bit positions.
    localparam int CTRL_EMUL = 0;
    localparam int CTRL_TASK_SWITCHED = 1;
    localparam int CTRL_FPPEND = 2;
    localparam int CTRL_MODE_LO = 3;
    localparam int CTRL_MODE_HI = 4;
    localparam int CTRL_CPL3 = 5;
    localparam int CTRL_ACEN = 6;
    // High ten bits of the operand offset for the real-mode limit check.
    localparam int CTRL_OFS_LO = 22;
    // Command register fields.
    localparam int CMD_OPC_LO = 0;
    localparam int CMD_OPC_HI = 7;
    localparam int CMD_DST_LO = 8;
    localparam int CMD_SRC_LO = 12;
    localparam int CMD_DKIND = 16;
    localparam int CMD_SKIND = 18;
    localparam int CMD_SEG_LO = 20;
    localparam int CMD_SEGOK = 23;
    localparam int CMD_WRITABLE = 24;
    localparam int CMD_PGOK = 25;
    localparam int CMD_ADDR_LO = 26;
    // Opcode second bytes (first byte 0x0f implied).
    localparam logic [7:0] OPC_RELEASE = 8'h77;
    localparam logic [7:0] OPC_MOV32_IN = 8'h6e;
    localparam logic [7:0] OPC_MOV32_OUT = 8'h7e;
    localparam logic [7:0] OPC_MOV64_IN = 8'h6f;
    localparam logic [7:0] OPC_MOV64_OUT = 8'h7f;
    localparam logic [7:0] OPC_PACK_SB = 8'h63;
    localparam logic [7:0] OPC_PACK_SW = 8'h6b;
    localparam logic [7:0] OPC_PACK_UB = 8'h67;
    localparam logic [15:0] TAG_EMPTY = 16'hffff;
    localparam logic [15:0] TAG_VALID = 16'h0000;
    localparam logic [15:0] TAG_RESET = 16'hffff;
    localparam logic [16:0] REAL_LIMIT = 17'h0ffff;
    localparam logic [7:0] SB_MAX = 8'h7f;
    localparam logic [7:0] SB_MIN = 8'h80;
    localparam logic [15:0] SW_MAX = 16'h7fff;
    localparam logic [15:0] SW_MIN = 16'h8000;
    localparam logic [7:0] UB_MAX = 8'hff;
    localparam logic [7:0] UB_MIN = 8'h00;
    // Fault codes in the status register.
    typedef enum logic [3:0] {
        FLT_NONE, FLT_INVALID_OP, FLT_NO_DEVICE, FLT_MATH, FLT_GEN_PROT,
        FLT_SS, FLT_PAGE, FLT_ALIGN, FLT_INT13
    } pmp_fault_t;
    typedef enum logic [1:0] {MODE_REAL, MODE_PROT, MODE_V86} pmp_mode_t;
    typedef enum logic [1:0] {KIND_PREG, KIND_IREG, KIND_MEM} pmp_kind_t;
    localparam logic [2:0] SEG_SS = 3'h2;
endpackage

// *** src/pmp_unit.sv ***
`timescale 1ns/1ns
// Functional notes
// - State release writes all ones to the tag word.
// - Every other packed instruction writes all zeros to the tag word.
// - Tag word is eight two-bit tags; code 11 is empty.
// - 32-bit move in loads low half and zero-fills the upper half.
// - 32-bit move out writes only the low 32 bits.
// - 32-bit move only between packed register and integer reg or memory.
// - 64-bit move in copies packed register or memory to packed register.
// - 64-bit move out copies packed register to packed reg or memory.
// - 64-bit move never memory to memory; one side is packed register.
// - Word pack to signed bytes, dest low, source high, saturated.
// - Dword pack to signed words, dest low, source high, saturated.
// - Pack destination is packed register; source register or memory.
// - Opcode 67 decodes as the unsigned-saturating word pack.
// - Unsigned pack clamps to ff above range and 00 below zero.
// - Protected mode: segment, stack, page and level-3 alignment faults.
// - Protected mode: move into a non-writable segment gives general protection fault.
// - Real mode: operand beyond address ffff raises interrupt 13.
// - Virtual-8086 mode adds page and alignment faults to real checks.
// - No instruction here changes the condition flags.
module pmp_unit #(
    parameter int NREGS = 8
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Result towards the core
    output logic flags_we
);
    logic [31:0] ctrl_q;
    logic [31:0] cmd_q;
    logic [63:0] src_q;
    logic [63:0] res_q;
    logic [15:0] tag_q;
    logic [3:0] fault_q;
    logic done_q;
    logic ires_we_q;
    logic mem_we_q;
    logic [63:0] preg_q [NREGS];
    logic acc, wr, go;
    logic [7:0] opc;
    logic [2:0] dsel, ssel, seg;
    logic [1:0] dkind, skind, mode;
    logic [5:0] addr_lo;
    logic [63:0] dval, sval, result;
    logic [3:0] fault_d;
    logic legal, uses_mem, wr_mem, is_pack;
    logic [7:0] size_b;
    logic [16:0] last_b;

    assign acc = psel && penable;
    assign wr = acc && pwrite;
    assign pready = 1'b1;
    assign go = wr && paddr == pmp_pkg::ADDR_CMD;
    assign flags_we = 1'b0;

    function automatic logic [7:0] sat_sb(input logic [15:0] w);
        if ($signed(w) > 16'sd127)
            return pmp_pkg::SB_MAX;
        else if ($signed(w) < -16'sd128)
            return pmp_pkg::SB_MIN;
        else
            return w[7:0];
    endfunction

    function automatic logic [15:0] sat_sw(input logic [31:0] d);
        if ($signed(d) > 32'sd32767)
            return pmp_pkg::SW_MAX;
        else if ($signed(d) < -32'sd32768)
            return pmp_pkg::SW_MIN;
        else
            return d[15:0];
    endfunction

    function automatic logic [7:0] sat_ub(input logic [15:0] w);
        if (w[15])
            return pmp_pkg::UB_MIN;
        else if (w > 16'h00ff)
            return pmp_pkg::UB_MAX;
        else
            return w[7:0];
    endfunction

    assign opc = pwdata[pmp_pkg::CMD_OPC_HI:pmp_pkg::CMD_OPC_LO];
    assign dsel = pwdata[pmp_pkg::CMD_DST_LO +: 3];
    assign ssel = pwdata[pmp_pkg::CMD_SRC_LO +: 3];
    assign dkind = pwdata[pmp_pkg::CMD_DKIND +: 2];
    assign skind = pwdata[pmp_pkg::CMD_SKIND +: 2];
    assign seg = pwdata[pmp_pkg::CMD_SEG_LO +: 3];
    assign addr_lo = pwdata[pmp_pkg::CMD_ADDR_LO +: 6];
    assign mode = ctrl_q[pmp_pkg::CTRL_MODE_HI:pmp_pkg::CTRL_MODE_LO];
    assign dval = preg_q[dsel];
    assign sval = (skind == pmp_pkg::KIND_PREG) ? preg_q[ssel] : src_q;

    // Operand legality and the data path.
    always_comb
    begin
        legal = 1'b1;
        is_pack = 1'b0;
        size_b = 8'h08;
        result = 64'h0;
        case (opc)
            pmp_pkg::OPC_RELEASE:
                size_b = 8'h00;
            pmp_pkg::OPC_MOV32_IN:
            begin
                legal = dkind == pmp_pkg::KIND_PREG &&
                        skind != pmp_pkg::KIND_PREG;
                size_b = 8'h04;
                result = {32'h0, src_q[31:0]};
            end
            pmp_pkg::OPC_MOV32_OUT:
            begin
                legal = skind == pmp_pkg::KIND_PREG &&
                        dkind != pmp_pkg::KIND_PREG;
                size_b = 8'h04;
                result = {32'h0, preg_q[ssel][31:0]};
            end
            pmp_pkg::OPC_MOV64_IN:
            begin
                legal = dkind == pmp_pkg::KIND_PREG &&
                        skind != pmp_pkg::KIND_IREG;
                result = sval;
            end
            pmp_pkg::OPC_MOV64_OUT:
            begin
                legal = skind == pmp_pkg::KIND_PREG &&
                        dkind != pmp_pkg::KIND_IREG;
                result = preg_q[ssel];
            end
            pmp_pkg::OPC_PACK_SB:
            begin
                is_pack = 1'b1;
                result = {sat_sb(sval[63:48]), sat_sb(sval[47:32]),
                          sat_sb(sval[31:16]), sat_sb(sval[15:0]),
                          sat_sb(dval[63:48]), sat_sb(dval[47:32]),
                          sat_sb(dval[31:16]), sat_sb(dval[15:0])};
            end
            pmp_pkg::OPC_PACK_SW:
            begin
                is_pack = 1'b1;
                result = {sat_sw(sval[63:32]), sat_sw(sval[31:0]),
                          sat_sw(dval[63:32]), sat_sw(dval[31:0])};
            end
            pmp_pkg::OPC_PACK_UB:
            begin
                is_pack = 1'b1;
                result = {sat_ub(sval[63:48]), sat_ub(sval[47:32]),
                          sat_ub(sval[31:16]), sat_ub(sval[15:0]),
                          sat_ub(dval[63:48]), sat_ub(dval[47:32]),
                          sat_ub(dval[31:16]), sat_ub(dval[15:0])};
            end
            default:
                legal = 1'b0;
        endcase
        if (is_pack)
            legal = dkind == pmp_pkg::KIND_PREG &&
                    skind != pmp_pkg::KIND_IREG;
    end

    assign uses_mem = opc != pmp_pkg::OPC_RELEASE &&
                      (dkind == pmp_pkg::KIND_MEM ||
                       skind == pmp_pkg::KIND_MEM);
    assign wr_mem = dkind == pmp_pkg::KIND_MEM;
    // The offset joins high bits from the control word and low bits from the
    // command, so the real-mode limit sees the whole 16-bit offset.
    assign last_b = {1'b0, ctrl_q[pmp_pkg::CTRL_OFS_LO +: 10], addr_lo} +
                    {9'h0, size_b} - 17'h1;

    // Fault priority: decode faults first, then address checks.
    always_comb
    begin
        fault_d = pmp_pkg::FLT_NONE;
        if (ctrl_q[pmp_pkg::CTRL_EMUL] || !legal)
            fault_d = pmp_pkg::FLT_INVALID_OP;
        else if (ctrl_q[pmp_pkg::CTRL_TASK_SWITCHED])
            fault_d = pmp_pkg::FLT_NO_DEVICE;
        else if (ctrl_q[pmp_pkg::CTRL_FPPEND])
            fault_d = pmp_pkg::FLT_MATH;
        else if (uses_mem)
        begin
            if (mode == pmp_pkg::MODE_PROT)
            begin
                if (!pwdata[pmp_pkg::CMD_SEGOK])
                    fault_d = (seg == pmp_pkg::SEG_SS) ? pmp_pkg::FLT_SS
                                                      : pmp_pkg::FLT_GEN_PROT;
                else if (wr_mem && !pwdata[pmp_pkg::CMD_WRITABLE])
                    fault_d = pmp_pkg::FLT_GEN_PROT;
                else if (!pwdata[pmp_pkg::CMD_PGOK])
                    fault_d = pmp_pkg::FLT_PAGE;
                else if (ctrl_q[pmp_pkg::CTRL_CPL3] &&
                         ctrl_q[pmp_pkg::CTRL_ACEN] &&
                         (addr_lo[2:0] & (size_b[2:0] - 3'h1)) != 3'h0)
                    fault_d = pmp_pkg::FLT_ALIGN;
            end
            else
            begin
                if (last_b > pmp_pkg::REAL_LIMIT)
                    fault_d = pmp_pkg::FLT_INT13;
                else if (mode == pmp_pkg::MODE_V86 &&
                         !pwdata[pmp_pkg::CMD_PGOK])
                    fault_d = pmp_pkg::FLT_PAGE;
                else if (mode == pmp_pkg::MODE_V86 &&
                         ctrl_q[pmp_pkg::CTRL_ACEN] &&
                         (addr_lo[2:0] & (size_b[2:0] - 3'h1)) != 3'h0)
                    fault_d = pmp_pkg::FLT_ALIGN;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_q <= 32'h0;
            src_q <= 64'h0;
        end
        else if (wr)
        begin
            if (paddr == pmp_pkg::ADDR_CTRL)
                ctrl_q <= pwdata;
            if (paddr == pmp_pkg::ADDR_SRC_LO)
                src_q[31:0] <= pwdata;
            if (paddr == pmp_pkg::ADDR_SRC_HI)
                src_q[63:32] <= pwdata;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cmd_q <= 32'h0;
            fault_q <= pmp_pkg::FLT_NONE;
            done_q <= 1'b0;
            ires_we_q <= 1'b0;
            mem_we_q <= 1'b0;
            res_q <= 64'h0;
        end
        else if (go)
        begin
            cmd_q <= pwdata;
            fault_q <= fault_d;
            done_q <= 1'b1;
            if (fault_d == pmp_pkg::FLT_NONE)
            begin
                res_q <= result;
                ires_we_q <= dkind == pmp_pkg::KIND_IREG;
                mem_we_q <= wr_mem;
            end
            else
            begin
                ires_we_q <= 1'b0;
                mem_we_q <= 1'b0;
            end
        end
    end

    // Software may also load the tag word directly, as the state save path.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            tag_q <= pmp_pkg::TAG_RESET;
        else if (go && fault_d == pmp_pkg::FLT_NONE)
            tag_q <= (opc == pmp_pkg::OPC_RELEASE)
                     ? pmp_pkg::TAG_EMPTY
                     : pmp_pkg::TAG_VALID;
        else if (wr && paddr == pmp_pkg::ADDR_TAG)
            tag_q <= pwdata[15:0];
    end

    for (genvar i = 0; i < NREGS; i++)
    begin : g_preg
        always_ff @(posedge pclk or negedge presetn)
        begin
            if (!presetn)
                preg_q[i] <= 64'h0;
            else if (go && fault_d == pmp_pkg::FLT_NONE &&
                     dkind == pmp_pkg::KIND_PREG && dsel == i &&
                     opc != pmp_pkg::OPC_RELEASE)
                preg_q[i] <= result;
        end
    end

    always_comb
    begin
        prdata = 32'h0;
        pslverr = 1'b0;
        if (paddr >= pmp_pkg::ADDR_PREG && paddr <= pmp_pkg::ADDR_PREG_LAST &&
            paddr[1:0] == 2'b00)
            prdata = paddr[2] ? preg_q[paddr[5:3] - 3'h4][63:32]
                              : preg_q[paddr[5:3] - 3'h4][31:0];
        else
            case (paddr)
                pmp_pkg::ADDR_CTRL: prdata = ctrl_q;
                pmp_pkg::ADDR_CMD: prdata = cmd_q;
                pmp_pkg::ADDR_SRC_LO: prdata = src_q[31:0];
                pmp_pkg::ADDR_SRC_HI: prdata = src_q[63:32];
                pmp_pkg::ADDR_RES_LO: prdata = res_q[31:0];
                pmp_pkg::ADDR_RES_HI: prdata = res_q[63:32];
                pmp_pkg::ADDR_TAG: prdata = {16'h0, tag_q};
                pmp_pkg::ADDR_STATUS:
                    prdata = {25'h0, mem_we_q, ires_we_q, done_q, fault_q};
                default: pslverr = acc;
            endcase
    end

    a_tag_release: assert property (@(posedge pclk) disable iff (!presetn)
        go && opc == pmp_pkg::OPC_RELEASE && fault_d == pmp_pkg::FLT_NONE
        |=> tag_q == 16'hffff) else $error("tag not empty");
    a_tag_valid: assert property (@(posedge pclk) disable iff (!presetn)
        go && opc != pmp_pkg::OPC_RELEASE && fault_d == pmp_pkg::FLT_NONE
        |=> tag_q == 16'h0000) else $error("tag not valid");
    a_fault_hold: assert property (@(posedge pclk) disable iff (!presetn)
        go && fault_d != pmp_pkg::FLT_NONE && !(wr && paddr ==
        pmp_pkg::ADDR_TAG) |=> $stable(tag_q) && !mem_we_q && !ires_we_q)
        else $error("fault changed state");
    a_emul_fault: assert property (@(posedge pclk) disable iff (!presetn)
        go && ctrl_q[pmp_pkg::CTRL_EMUL]
        |=> fault_q == pmp_pkg::FLT_INVALID_OP)
        else $error("no invalid opcode");
    a_mov32_zero: assert property (@(posedge pclk) disable iff (!presetn)
        go && opc == pmp_pkg::OPC_MOV32_IN && fault_d == pmp_pkg::FLT_NONE
        |=> res_q[63:32] == 32'h0 && res_q[31:0] == $past(src_q[31:0]))
        else $error("upper half not zero");
    a_mov32_out: assert property (@(posedge pclk) disable iff (!presetn)
        go && opc == pmp_pkg::OPC_MOV32_OUT && fault_d == pmp_pkg::FLT_NONE
        |=> res_q[63:32] == 32'h0) else $error("move out wide");
    a_ro_seg: assert property (@(posedge pclk) disable iff (!presetn)
        go && legal && ctrl_q[2:0] == 3'h0 && mode == pmp_pkg::MODE_PROT &&
        wr_mem && pwdata[pmp_pkg::CMD_SEGOK] && !pwdata[pmp_pkg::CMD_WRITABLE]
        |=> fault_q == pmp_pkg::FLT_GEN_PROT)
        else $error("ro write");
    a_real_limit: assert property (@(posedge pclk) disable iff (!presetn)
        go && legal && ctrl_q[2:0] == 3'h0 && mode == pmp_pkg::MODE_REAL &&
        uses_mem && last_b > 17'h0ffff |=> fault_q == pmp_pkg::FLT_INT13)
        else $error("no int13");
    a_no_flags: assert property (@(posedge pclk) disable iff (!presetn)
        !flags_we) else $error("flags written");
endmodule // pmp_unit

// *** sim/pmp_core_model.sv ***
`timescale 1ns/1ns
// Core side of the unit: issues register requests as the processor would.
module pmp_core_model (
    // Clock
    input wire logic pclk,
    // APB master
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [11:0] paddr,
    output logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    logic hung = 1'b0;

    initial
    begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
    end

    task automatic xfer(input logic wr, input logic [11:0] a,
        input logic [31:0] d, output logic [31:0] q, output logic err);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 16);
        hung = hung | (pready !== 1'b1);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // Released lines flip so a stale value never looks valid.
        paddr <= ~a;
        pwdata <= ~d;
    endtask
endmodule // pmp_core_model

// *** sim/testbench.sv ***
`timescale 1ns/1ns
module testbench;
    localparam pmp_pkg::pmp_kind_t KP = pmp_pkg::KIND_PREG;
    localparam pmp_pkg::pmp_kind_t KI = pmp_pkg::KIND_IREG;
    localparam pmp_pkg::pmp_kind_t KM = pmp_pkg::KIND_MEM;
    localparam pmp_pkg::pmp_fault_t FN = pmp_pkg::FLT_NONE;
    localparam pmp_pkg::pmp_fault_t INV = pmp_pkg::FLT_INVALID_OP;
    logic pclk;
    logic presetn;
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic flags_we;
    int mismatches = 0;
    int samples_checked = 0;
    int seed = 14;
    logic [63:0] m_preg [8];
    logic [15:0] m_tag;
    logic [31:0] rd;
    logic er;

    pmp_unit pmp_unit_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .flags_we(flags_we));
    pmp_core_model pmp_core_model_inst (.pclk(pclk), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr));

    initial
    begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end

    task automatic final_report();
        $display("mismatches=%0d checked=%0d", mismatches, samples_checked);
        if (mismatches == 0 && samples_checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            mismatches++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
        if (pmp_core_model_inst.hung)
        begin
            mismatches++;
            $display("MISMATCH t=%0t bus timeout", $time);
            final_report();
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        pmp_core_model_inst.xfer(1'b1, a, d, rd, er);
    endtask

    task automatic rdc(input logic [11:0] a, input logic [31:0] e,
        input logic ee);
        pmp_core_model_inst.xfer(1'b0, a, 32'h0, rd, er);
        chk(rd, e);
        chk({31'h0, er}, {31'h0, ee});
    endtask

    function automatic logic [31:0] cmd(input logic [7:0] op,
        input logic [2:0] d, input logic [2:0] s, input pmp_pkg::pmp_kind_t dk,
        input pmp_pkg::pmp_kind_t sk, input logic [11:0] hi = 12'h038);
        return {hi, sk, dk, 1'b0, s, 1'b0, d, op};
    endfunction

    task automatic run(input logic [31:0] c, input pmp_pkg::pmp_fault_t f);
        logic ok;
        ok = f == FN;
        wr(pmp_pkg::ADDR_CMD, c);
        pmp_core_model_inst.xfer(1'b0, pmp_pkg::ADDR_STATUS, 32'h0, rd, er);
        chk({25'h0, rd[6:0]}, {25'h0, ok && c[17:16] == KM,
            ok && c[17:16] == KI, 1'b1, f});
    endtask

    task automatic verify(input int i);
        rdc(pmp_pkg::ADDR_TAG, {16'h0, m_tag}, 1'b0);
        rdc(pmp_pkg::ADDR_PREG + 12'(8 * i), m_preg[i][31:0], 1'b0);
        rdc(pmp_pkg::ADDR_PREG + 12'(8 * i + 4), m_preg[i][63:32], 1'b0);
        chk({31'h0, flags_we}, 32'h0);
    endtask

    task automatic ld(input int i, input logic [63:0] v);
        wr(pmp_pkg::ADDR_SRC_LO, v[31:0]);
        wr(pmp_pkg::ADDR_SRC_HI, v[63:32]);
        run(cmd(pmp_pkg::OPC_MOV64_IN, 3'(i), 3'h0, KP, KM), FN);
        m_preg[i] = v;
        m_tag = pmp_pkg::TAG_VALID;
        verify(i);
    endtask

    function automatic logic [63:0] pk(input logic [7:0] op,
        input logic [63:0] a, input logic [63:0] b);
        logic [63:0] r;
        int v;
        for (int i = 0; i < 8; i++)
        begin
            v = (i < 4) ? $signed(a[16*i+:16]) : $signed(b[16*i-64+:16]);
            if (op == pmp_pkg::OPC_PACK_UB)
                r[8*i+:8] = v > 255 ? 8'hff : v < 0 ? 8'h00 : v[7:0];
            else
                r[8*i+:8] = v > 127 ? 8'h7f : v < -128 ? 8'h80 : v[7:0];
        end
        for (int i = 0; i < 4 && op == pmp_pkg::OPC_PACK_SW; i++)
        begin
            v = (i < 2) ? $signed(a[32*i+:32]) : $signed(b[32*i-64+:32]);
            r[16*i+:16] = v > 32767 ? 16'h7fff : v < -32768 ? 16'h8000 :
                v[15:0];
        end
        return r;
    endfunction

    initial
    begin
        logic [63:0] bnd [4];
        logic [7:0] ops [3];
        logic [31:0] fc [12];
        logic [11:0] fh [12];
        pmp_pkg::pmp_fault_t ff [12];
        pmp_pkg::pmp_kind_t sk;
        logic [63:0] v;
        int d;
        bnd = '{64'h7fff_8000_0080_ff7f, 64'h007f_ff80_0100_00ff,
            64'hffff_7fff_8000_0000, 64'h0000_1234_ffff_8000};
        ops = '{pmp_pkg::OPC_PACK_SB, pmp_pkg::OPC_PACK_SW,
            pmp_pkg::OPC_PACK_UB};
        fc = '{32'h09, 32'h0a, 32'h0c, 32'h08, 32'h08, 32'h08, 32'h08,
            32'h68, 32'h10, 32'h50, 32'h11, 32'h02};
        fh = '{12'h038, 12'h038, 12'h038, 12'h030, 12'h032, 12'h028,
            12'h018, 12'h078, 12'h018, 12'h078, 12'h038, 12'h038};
        ff = '{INV, pmp_pkg::FLT_NO_DEVICE, pmp_pkg::FLT_MATH,
            pmp_pkg::FLT_GEN_PROT, pmp_pkg::FLT_SS, pmp_pkg::FLT_GEN_PROT,
            pmp_pkg::FLT_PAGE, pmp_pkg::FLT_ALIGN, pmp_pkg::FLT_PAGE,
            pmp_pkg::FLT_ALIGN, INV, pmp_pkg::FLT_NO_DEVICE};
        presetn = 1'b0;
        m_tag = pmp_pkg::TAG_RESET;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rdc(pmp_pkg::ADDR_TAG, 32'h0000ffff, 1'b0);
        rdc(12'h100, 32'h0, 1'b1);
        wr(pmp_pkg::ADDR_CTRL, 32'h08);
        for (int i = 0; i < 8; i++)
        begin
            v = {$random(seed), $random(seed)};
            wr(pmp_pkg::ADDR_SRC_LO, v[31:0]);
            wr(pmp_pkg::ADDR_SRC_HI, v[63:32]);
            run(cmd(pmp_pkg::OPC_MOV32_IN, 3'(i), 3'h0, KP, KI), FN);
            m_preg[i] = {32'h0, v[31:0]};
            m_tag = pmp_pkg::TAG_VALID;
            verify(i);
        end
        for (int i = 4; i < 8; i++)
            ld(i, {$random(seed), $random(seed)});
        for (int k = 0; k < 12; k++)
        begin
            d = k % 4;
            ld(d, bnd[d]);
            sk = (k < 6) ? KP : KM;
            v = (k < 6) ? m_preg[4 + d] : bnd[(k + 1) % 4];
            wr(pmp_pkg::ADDR_SRC_LO, v[31:0]);
            wr(pmp_pkg::ADDR_SRC_HI, v[63:32]);
            run(cmd(ops[k % 3], 3'(d), 3'(4 + d), KP, sk), FN);
            m_preg[d] = pk(ops[k % 3], m_preg[d], v);
            verify(d);
        end
        run(cmd(pmp_pkg::OPC_MOV64_IN, 3'h6, 3'h5, KP, KP), FN);
        m_preg[6] = m_preg[5];
        verify(6);
        run(cmd(pmp_pkg::OPC_MOV64_OUT, 3'h7, 3'h6, KP, KP), FN);
        m_preg[7] = m_preg[6];
        verify(7);
        run(cmd(pmp_pkg::OPC_MOV64_OUT, 3'h0, 3'h4, KM, KP), FN);
        rdc(pmp_pkg::ADDR_RES_LO, m_preg[4][31:0], 1'b0);
        rdc(pmp_pkg::ADDR_RES_HI, m_preg[4][63:32], 1'b0);
        run(cmd(pmp_pkg::OPC_MOV32_OUT, 3'h0, 3'h3, KI, KP), FN);
        rdc(pmp_pkg::ADDR_RES_LO, m_preg[3][31:0], 1'b0);
        rdc(pmp_pkg::ADDR_RES_HI, 32'h0, 1'b0);
        for (int k = 0; k < 12; k++)
        begin
            wr(pmp_pkg::ADDR_CTRL, fc[k]);
            run(cmd(pmp_pkg::OPC_MOV64_OUT, 3'h0, 3'h1, KM, KP, fh[k]),
                ff[k]);
            rdc(pmp_pkg::ADDR_RES_LO, m_preg[3][31:0], 1'b0);
        end
        wr(pmp_pkg::ADDR_CTRL, 32'h08);
        run(cmd(pmp_pkg::OPC_MOV32_IN, 3'h2, 3'h1, KP, KP), INV);
        run(cmd(pmp_pkg::OPC_MOV64_IN, 3'h2, 3'h1, KM, KM), INV);
        run(cmd(pmp_pkg::OPC_PACK_SB, 3'h2, 3'h1, KM, KP), INV);
        verify(2);
        run(cmd(pmp_pkg::OPC_RELEASE, 3'h0, 3'h0, KP, KP), FN);
        m_tag = pmp_pkg::TAG_EMPTY;
        verify(0);
        wr(pmp_pkg::ADDR_TAG, 32'h0000_1b4e);
        rdc(pmp_pkg::ADDR_TAG, 32'h0000_1b4e, 1'b0);
        wr(pmp_pkg::ADDR_CTRL, 32'h09);
        run(cmd(pmp_pkg::OPC_RELEASE, 3'h0, 3'h0, KP, KP), INV);
        m_tag = 16'h1b4e;
        verify(0);
        wr(pmp_pkg::ADDR_CTRL, 32'h10);
        run(cmd(pmp_pkg::OPC_RELEASE, 3'h0, 3'h0, KP, KP), FN);
        m_tag = pmp_pkg::TAG_EMPTY;
        verify(0);
        ld(1, bnd[2]);
        wr(pmp_pkg::ADDR_CTRL, 32'hffc0_0000);
        run(cmd(pmp_pkg::OPC_MOV64_OUT, 3'h0, 3'h4, KM, KP, 12'he38),
            FN);
        rdc(pmp_pkg::ADDR_RES_LO, m_preg[4][31:0], 1'b0);
        run(cmd(pmp_pkg::OPC_MOV64_OUT, 3'h0, 3'h5, KM, KP, 12'he78),
            pmp_pkg::FLT_INT13);
        rdc(pmp_pkg::ADDR_RES_HI, m_preg[4][63:32], 1'b0);
        final_report();
    end
endmodule // testbench
